/* File: wdc_consts.vh */
// Constants for the watchpoint and debug control block
`ifndef WDC_CONSTS_VH
`define WDC_CONSTS_VH

// ==========================================================
// Scan chain field layout
`define WDC_SCAN_LEN 38
`define WDC_SCAN_RW 37
`define WDC_SCAN_ADDR_HI 36
`define WDC_SCAN_ADDR_LO 32
`define WDC_SCAN_DATA_HI 31

// ==========================================================
// Register addresses
`define WDC_ADDR_DBG_CTRL 5'h00
`define WDC_WP0_BASE 2'h1
`define WDC_WP1_BASE 2'h2
`define WDC_SUB_ADDR_VAL 3'h0
`define WDC_SUB_ADDR_MSK 3'h1
`define WDC_SUB_DATA_VAL 3'h2
`define WDC_SUB_DATA_MSK 3'h3
`define WDC_SUB_CTRL_VAL 3'h4
`define WDC_SUB_CTRL_MSK 3'h5

// ==========================================================
// Debug control fields and reset value
`define WDC_DCTL_DISABLE 5
`define WDC_DCTL_MONITOR 4
`define WDC_DCTL_STEP 3
`define WDC_DCTL_INHIBIT 2
`define WDC_DCTL_DEBUG_REQUEST_BIT 1
`define WDC_DCTL_DEBUG_ACKNOWLEDGE 0
`define WDC_DCTL_RESET 6'h10

// ==========================================================
// Watchpoint control fields and reset values
`define WDC_WPC_ENABLE 8
`define WDC_WPC_MODE 3
`define WDC_WPC_CARE 8'hf2
`define WDC_WPC_BASE_CARE 8'h32
`define WDC_WPCV_RESET 9'h000
`define WDC_WPCM_RESET 8'h00
`define WDC_WORD_RESET 32'h00000000

`endif

/* File: wdc_sync.v */
// Two-flop synchroniser for inputs from outside the mclk domain
`timescale 1ns/1ps
module wdc_sync #(
  parameter WIDTH = 1
) (
  input wire mclk, // Core clock
  input wire rst_n, // Async reset, active low
  input wire [WIDTH-1:0] d, // Asynchronous input
  output wire [WIDTH-1:0] q // Synchronised output
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule

/* File: wdc_watchpoint.v */
// One instruction-fetch watchpoint comparator with its chaining latch
`include "wdc_consts.vh"
`timescale 1ns/1ps
module wdc_watchpoint (
  input wire mclk, // Core clock
  input wire rst_n, // Async reset, active low
  input wire compEnable, // Comparators enabled
  input wire ctrlWrite, // Control value register written
  input wire tstRstSync_n, // Synchronised test reset, active low
  input wire [31:0] addrValue, // Address value
  input wire [31:0] addrMask, // Address mask, 1 ignores bit
  input wire [31:0] dataValue, // Data value
  input wire [31:0] dataMask, // Data mask, 1 ignores bit
  input wire [8:0] ctrlValue, // Control value
  input wire [7:0] ctrlMask, // Control mask
  input wire [31:0] fetchAddr, // Fetch address
  input wire [31:0] fetchData, // Fetched instruction
  input wire instrSetState, // 1 compact, 0 standard fetch
  input wire fetchNotTranslate, // 0 user, 1 privileged
  input wire externalCondition, // External condition line
  input wire chainIn, // Chain input
  input wire rangeIn, // Range input
  output wire match, // Enabled full match
  output wire addrMatch, // Address comparator result
  output wire linkOutput // Chaining latch
);
  wire addrOk;
  wire dataOk;
  wire [7:0] ctlSig;
  wire ctlOk;
  wire ctlBaseOk;
  wire latchWe;
  reg linkOutput_q;

  assign addrOk = ~|((fetchAddr ^ addrValue) & ~addrMask);
  assign dataOk = ~|((fetchData ^ dataValue) & ~dataMask);
  // Bits 2 and 0 are don't care in fetch form; bit 3 cannot be masked
  assign ctlSig = {rangeIn, chainIn, externalCondition,
    fetchNotTranslate, 1'b0, 1'b0, instrSetState, 1'b0};
  assign ctlOk = ~|((ctlSig ^ ctrlValue[7:0]) & ~ctrlMask & `WDC_WPC_CARE) &
    ~ctrlValue[`WDC_WPC_MODE];
  // Latch enable leaves out chain and range to avoid a loop
  assign ctlBaseOk = ~|((ctlSig ^ ctrlValue[7:0]) & ~ctrlMask &
    `WDC_WPC_BASE_CARE) & ~ctrlValue[`WDC_WPC_MODE];
  assign latchWe = addrOk & ctlBaseOk & compEnable;
  assign match = addrOk & dataOk & ctlOk & compEnable &
    ctrlValue[`WDC_WPC_ENABLE];
  assign addrMatch = addrOk & compEnable;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      linkOutput_q <= 1'b0;
    end else if (ctrlWrite || !tstRstSync_n) begin
      linkOutput_q <= 1'b0;
    end else if (latchWe) begin
      linkOutput_q <= dataOk;
    end
  end

  assign linkOutput = linkOutput_q;
endmodule

/* File: wdc_top.v */
// Watchpoint and debug control logic reached through scan chain 2
`include "wdc_consts.vh"
`timescale 1ns/1ps
// Summary of operation
// - Bit 1 matches instruction-set state
// - Bit 4 matches fetch privilege signal
// - Bit 5 matches per-watchpoint external condition
// - Watchpoint 1 latch feeds watchpoint 0 chain
// - Chain latch loads data compare result
// - Chain latch cleared on control value write, test reset
// - Watchpoint 1 address match feeds range
// - Breakpoint only when enable bit set
// - Six-bit debug control, rw high writes
// - Control bit 5 disables comparators
// - Reset flag disables until chain access
// - Bit 4 selects monitor or halt
// - Monitor bit set at reset
// - Bit 3 drives single-step hardware
// - Bit 2 blocks processor interrupts
// - Bits 1,0 force request and acknowledge
// - Interrupts only when acknowledge, inhibit clear
// - Synchronised request ORed with external request
// - Periphery acknowledge is core OR bit
// - Step runs one instruction then reenters
module wdc_top (
  input wire mclk, // Core clock, 200 MHz
  input wire rst_n, // Debug reset, async, active low
  input wire tck, // Scan clock, sampled
  input wire tdi, // Scan data in
  input wire scanCapture, // Capture state of scan controller
  input wire scanShift, // Shift state of scan controller
  input wire scanUpdate, // Update state of scan controller
  input wire scanChain2Sel, // Scan chain 2 selected
  input wire tstRst_n, // Test reset, active low
  input wire [31:0] fetchAddr, // Instruction fetch address
  input wire [31:0] fetchData, // Fetched instruction
  input wire fetchValid, // Fetch in this cycle
  input wire instrSetState, // 1 compact, 0 standard fetch
  input wire fetchNotTranslate, // 0 user, 1 privileged fetch
  input wire [1:0] externalCondition, // Per-watchpoint conditions
  input wire externalDebugRequest, // External debug request pin
  input wire coreDebugAck, // Core is in debug state
  input wire instrExecuted, // Core finished one instruction
  input wire irqIn, // Interrupt request to gate
  input wire fiqIn, // Fast interrupt request to gate
  output reg tdo, // Scan data out
  output reg instrBreakpointSignal, // Halt-mode breakpoint
  output reg prefetchAbort, // Monitor-mode breakpoint abort
  output reg debugRequestCore, // Debug request to core
  output reg debugAcknowledge, // Acknowledge at periphery
  output reg irqCore, // Gated interrupt request
  output reg fiqCore // Gated fast interrupt request
);
  // ========================================================
  // Single-step states
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_ARMED = 2'b01;
  localparam [1:0] ST_RUN = 2'b10;
  localparam [1:0] ST_BREAK = 2'b11;

  // ========================================================
  // Declarations
  wire tckS;
  wire tdiS;
  wire captureS;
  wire shiftS;
  wire updateS;
  wire sel2S;
  wire tstRstS_n;
  wire [1:0] extCondS;
  wire extReqS;
  wire reqBitS;
  reg tckPrev_q;
  reg [`WDC_SCAN_LEN-1:0] scan_q;
  reg [5:0] dbgCtrl_q;
  reg compDisFlag_q;
  reg [1:0] stepState_q;
  reg [1:0] stepState_d;
  reg [31:0] readData;
  wire tckRise;
  wire chainAccess;
  wire wrStrobe;
  wire [4:0] scanAddr;
  wire [1:0] wpHit;
  wire compEnable;
  wire interruptInhibit;
  wire ackOut;
  wire bpHit;
  wire [1:0] wpMatch;
  wire [1:0] wpAddrMatch;
  wire [1:0] wpLink;
  wire [1:0] cvWrite;
  reg [31:0] wpAddrVal_q [0:1];
  reg [31:0] wpAddrMsk_q [0:1];
  reg [31:0] wpDataVal_q [0:1];
  reg [31:0] wpDataMsk_q [0:1];
  reg [8:0] wpCtrlVal_q [0:1];
  reg [7:0] wpCtrlMsk_q [0:1];

  // One-hot watchpoint select from a scan address
  function [1:0] wdcWpSel;
    input [4:0] addr;
    begin
      wdcWpSel = 2'b00;
      if (addr[4:3] == `WDC_WP0_BASE) begin
        wdcWpSel = 2'b01;
      end else if (addr[4:3] == `WDC_WP1_BASE) begin
        wdcWpSel = 2'b10;
      end
    end
  endfunction

  // ========================================================
  // Synchronisers
  wdc_sync #(
    .WIDTH(10)
  ) uPinSync (
    .mclk(mclk),
    .rst_n(rst_n),
    .d({tck, tdi, scanCapture, scanShift, scanUpdate, scanChain2Sel,
      tstRst_n, externalCondition, externalDebugRequest}),
    .q({tckS, tdiS, captureS, shiftS, updateS, sel2S,
      tstRstS_n, extCondS, extReqS})
  );

  wdc_sync #(
    .WIDTH(1)
  ) uReqSync (
    .mclk(mclk),
    .rst_n(rst_n),
    .d(dbgCtrl_q[`WDC_DCTL_DEBUG_REQUEST_BIT]),
    .q(reqBitS)
  );

  // ========================================================
  // Scan chain 2 shifter
  assign tckRise = tckS & ~tckPrev_q;
  assign chainAccess = tckRise & sel2S & (captureS | updateS);
  assign scanAddr = scan_q[`WDC_SCAN_ADDR_HI:`WDC_SCAN_ADDR_LO];
  assign wrStrobe = tckRise & sel2S & updateS & ~captureS & ~shiftS &
    scan_q[`WDC_SCAN_RW];
  assign wpHit = wdcWpSel(scanAddr);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tckPrev_q <= 1'b0;
      scan_q <= {`WDC_SCAN_LEN{1'b0}};
      tdo <= 1'b0;
    end else begin
      tckPrev_q <= tckS;
      tdo <= scan_q[0];
      if (tckRise && sel2S) begin
        if (captureS) begin
          scan_q[`WDC_SCAN_DATA_HI:0] <= readData;
        end else if (shiftS) begin
          scan_q <= {tdiS, scan_q[`WDC_SCAN_LEN-1:1]};
        end
      end
    end
  end

  // Read mux; unmapped addresses read as zero
  always @* begin
    readData = 32'h00000000;
    if (scanAddr == `WDC_ADDR_DBG_CTRL) begin
      readData = {26'h0, dbgCtrl_q};
    end else if (wdcWpSel(scanAddr) != 2'b00) begin
      case (scanAddr[2:0])
        `WDC_SUB_ADDR_VAL: readData = wpAddrVal_q[scanAddr[4]];
        `WDC_SUB_ADDR_MSK: readData = wpAddrMsk_q[scanAddr[4]];
        `WDC_SUB_DATA_VAL: readData = wpDataVal_q[scanAddr[4]];
        `WDC_SUB_DATA_MSK: readData = wpDataMsk_q[scanAddr[4]];
        `WDC_SUB_CTRL_VAL: readData = {23'h0, wpCtrlVal_q[scanAddr[4]]};
        `WDC_SUB_CTRL_MSK: readData = {24'h000000, wpCtrlMsk_q[scanAddr[4]]};
        default: readData = 32'h00000000;
      endcase
    end
  end

  // ========================================================
  // Debug control register and reset-time disable flag
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dbgCtrl_q <= `WDC_DCTL_RESET;
      compDisFlag_q <= 1'b1;
    end else begin
      if (chainAccess) begin
        compDisFlag_q <= 1'b0;
      end
      if (wrStrobe && scanAddr == `WDC_ADDR_DBG_CTRL) begin
        dbgCtrl_q <= scan_q[5:0];
      end
    end
  end

  assign compEnable = ~dbgCtrl_q[`WDC_DCTL_DISABLE] & ~compDisFlag_q;

  // ========================================================
  // Watchpoint registers and comparators
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : gWp
      assign cvWrite[i] = wrStrobe & wpHit[i] &
        (scanAddr[2:0] == `WDC_SUB_CTRL_VAL);

      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          wpAddrVal_q[i] <= `WDC_WORD_RESET;
          wpAddrMsk_q[i] <= `WDC_WORD_RESET;
          wpDataVal_q[i] <= `WDC_WORD_RESET;
          wpDataMsk_q[i] <= `WDC_WORD_RESET;
          wpCtrlVal_q[i] <= `WDC_WPCV_RESET;
          wpCtrlMsk_q[i] <= `WDC_WPCM_RESET;
        end else if (wrStrobe && wpHit[i]) begin
          case (scanAddr[2:0])
            `WDC_SUB_ADDR_VAL: wpAddrVal_q[i] <= scan_q[31:0];
            `WDC_SUB_ADDR_MSK: wpAddrMsk_q[i] <= scan_q[31:0];
            `WDC_SUB_DATA_VAL: wpDataVal_q[i] <= scan_q[31:0];
            `WDC_SUB_DATA_MSK: wpDataMsk_q[i] <= scan_q[31:0];
            `WDC_SUB_CTRL_VAL: wpCtrlVal_q[i] <= scan_q[8:0];
            `WDC_SUB_CTRL_MSK: wpCtrlMsk_q[i] <= scan_q[7:0];
            default: wpCtrlMsk_q[i] <= wpCtrlMsk_q[i];
          endcase
        end
      end

      // Only watchpoint 0 has a partner; watchpoint 1 sees zeros
      wdc_watchpoint uWp (
        .mclk(mclk),
        .rst_n(rst_n),
        .compEnable(compEnable),
        .ctrlWrite(cvWrite[i]),
        .tstRstSync_n(tstRstS_n),
        .addrValue(wpAddrVal_q[i]),
        .addrMask(wpAddrMsk_q[i]),
        .dataValue(wpDataVal_q[i]),
        .dataMask(wpDataMsk_q[i]),
        .ctrlValue(wpCtrlVal_q[i]),
        .ctrlMask(wpCtrlMsk_q[i]),
        .fetchAddr(fetchAddr),
        .fetchData(fetchData),
        .instrSetState(instrSetState),
        .fetchNotTranslate(fetchNotTranslate),
        .externalCondition(extCondS[i]),
        .chainIn((i == 0) ? wpLink[1] : 1'b0),
        .rangeIn((i == 0) ? wpAddrMatch[1] : 1'b0),
        .match(wpMatch[i]),
        .addrMatch(wpAddrMatch[i]),
        .linkOutput(wpLink[i])
      );
    end
  endgenerate

  // ========================================================
  // Single-step sequencer
  // Step bit must only change in debug state; not for monitor mode
  always @* begin
    stepState_d = stepState_q;
    case (stepState_q)
      ST_IDLE: begin
        if (coreDebugAck && dbgCtrl_q[`WDC_DCTL_STEP]) begin
          stepState_d = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (!dbgCtrl_q[`WDC_DCTL_STEP]) begin
          stepState_d = ST_IDLE;
        end else if (!coreDebugAck) begin
          stepState_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (instrExecuted) begin
          stepState_d = ST_BREAK;
        end
      end
      ST_BREAK: begin
        if (coreDebugAck) begin
          stepState_d = ST_IDLE;
        end
      end
      default: stepState_d = ST_IDLE;
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stepState_q <= ST_IDLE;
    end else begin
      stepState_q <= stepState_d;
    end
  end

  // ========================================================
  // Core-facing outputs
  assign bpHit = fetchValid & (|wpMatch);
  assign ackOut = coreDebugAck | dbgCtrl_q[`WDC_DCTL_DEBUG_ACKNOWLEDGE];
  assign interruptInhibit = dbgCtrl_q[`WDC_DCTL_INHIBIT];

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      instrBreakpointSignal <= 1'b0;
      prefetchAbort <= 1'b0;
      debugRequestCore <= 1'b0;
      debugAcknowledge <= 1'b0;
      irqCore <= 1'b0;
      fiqCore <= 1'b0;
    end else begin
      // Monitor mode turns breakpoints into prefetch aborts
      instrBreakpointSignal <= (bpHit & ~dbgCtrl_q[`WDC_DCTL_MONITOR]) |
        (stepState_q == ST_BREAK);
      prefetchAbort <= bpHit & dbgCtrl_q[`WDC_DCTL_MONITOR];
      debugRequestCore <= reqBitS | extReqS;
      debugAcknowledge <= ackOut;
      irqCore <= irqIn & ~ackOut & ~interruptInhibit;
      fiqCore <= fiqIn & ~ackOut & ~interruptInhibit;
    end
  end
endmodule

/* File: wdc_dbg_model.sv */
// Behavioural scan debugger driving chain 2 of the block
`timescale 1ns/1ps
module wdc_dbg_model (
  output logic tck, // Scan clock, still between frames
  output logic tdi, // Scan data to block
  output logic scanCapture, // Capture state
  output logic scanShift, // Shift state
  output logic scanUpdate, // Update state
  output logic scanChain2Sel, // Chain 2 select
  input wire logic tdo // Scan data from block
);
  initial begin
    {tck, tdi, scanCapture, scanShift, scanUpdate, scanChain2Sel} = 6'h0;
  end
  // ==========================================================
  // Frame drive
  // 24 ns levels outlast the block's three-cycle sampling delay
  task automatic pulse();
    #24 tck = 1'b1;
    #24 tck = 1'b0;
  endtask
  // Capture reads the address shifted in the previous frame
  task automatic frame(input logic [37:0] sIn, output logic [37:0] sOut);
    integer i;
    begin
      // Offset keeps scan edges clear of the core clock edges
      #0.3 scanChain2Sel = 1'b1;
      scanCapture = 1'b1;
      pulse();
      scanCapture = 1'b0;
      scanShift = 1'b1;
      for (i = 0; i < 38; i++) begin
        tdi = sIn[i];
        #24 sOut[i] = tdo;
        tck = 1'b1;
        #24 tck = 1'b0;
      end
      scanShift = 1'b0;
      scanUpdate = 1'b1;
      pulse();
      scanUpdate = 1'b0;
      scanChain2Sel = 1'b0;
      tdi = ~tdi;
    end
  endtask
endmodule

/* File: wdc_chk.sv */
// Port assertions for the watchpoint and debug control block
`timescale 1ns/1ps
module wdc_chk (
  input wire mclk, // Clock
  input wire rst_n, // Reset
  input wire scanCapture, // Capture
  input wire scanShift, // Shift
  input wire fetchValid, // Fetch
  input wire externalDebugRequest, // Request pin
  input wire coreDebugAck, // Core ack
  input wire instrExecuted, // Step done
  input wire irqIn, // Irq
  input wire fiqIn, // Fiq
  input wire tdo, // Scan out
  input wire instrBreakpointSignal, // Break
  input wire prefetchAbort, // Abort
  input wire debugRequestCore, // Request
  input wire debugAcknowledge, // Ack out
  input wire irqCore, // Gated irq
  input wire fiqCore // Gated fiq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Assertions
  ack_core_a: assert property (coreDebugAck |=> debugAcknowledge)
    else $error("acknowledge missing");
  irq_gate_a: assert property (irqCore |->
    !debugAcknowledge && $past(irqIn))
    else $error("irq passed while blocked");
  fiq_gate_a: assert property (fiqCore |->
    !debugAcknowledge && $past(fiqIn))
    else $error("fiq passed while blocked");
  dbg_block_a: assert property (coreDebugAck |=>
    !irqCore && !fiqCore) else $error("interrupt in debug state");
  ext_req_a: assert property (externalDebugRequest [*4] |=>
    debugRequestCore) else $error("external request lost");
  abort_src_a: assert property (prefetchAbort |->
    $past(fetchValid) || $past(fetchValid, 2)) else $error("abort without fetch");
  bp_src_a: assert property ($rose(instrBreakpointSignal) |->
    $past(fetchValid) || $past(fetchValid, 2) || $past(instrExecuted) ||
    $past(instrExecuted, 2)) else $error("break without cause");
  tdo_hold_a: assert property ((!scanShift && !scanCapture) [*5] |=>
    $stable(tdo)) else $error("scan out moved while idle");
  cover property (prefetchAbort);
  cover property (instrBreakpointSignal);
  cover property (irqCore);
endmodule
bind wdc_top wdc_chk wdc_chk_inst (.mclk(mclk), .rst_n(rst_n),
  .scanCapture(scanCapture), .scanShift(scanShift), .fetchValid(fetchValid),
  .externalDebugRequest(externalDebugRequest), .coreDebugAck(coreDebugAck),
  .instrExecuted(instrExecuted), .irqIn(irqIn), .fiqIn(fiqIn), .tdo(tdo),
  .instrBreakpointSignal(instrBreakpointSignal), .irqCore(irqCore),
  .prefetchAbort(prefetchAbort), .debugRequestCore(debugRequestCore),
  .debugAcknowledge(debugAcknowledge), .fiqCore(fiqCore));

/* File: tb.sv */
// Self-checking bench for the watchpoint and debug control block
`include "wdc_consts.vh"
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic tstRst_n = 1'b0;
  logic [31:0] fetchAddr = 32'h0;
  logic [31:0] fetchData = 32'h0;
  logic fetchValid = 1'b0;
  logic instrSetState = 1'b0;
  logic fetchNotTranslate = 1'b0;
  logic [1:0] externalCondition = 2'h0;
  logic externalDebugRequest = 1'b0;
  logic coreDebugAck = 1'b0;
  logic instrExecuted = 1'b0;
  logic irqIn = 1'b0;
  logic fiqIn = 1'b0;
  wire tck, tdi, scanCapture, scanShift, scanUpdate, scanChain2Sel, tdo;
  wire instrBreakpointSignal, prefetchAbort, debugRequestCore;
  wire debugAcknowledge, irqCore, fiqCore;
  integer num_errors = 0;
  integer n_compared = 0;
  integer seed = 32'h46cd;
  integer i;
  logic [5:0] v;
  logic [31:0] a0, a1;
  always #2.5 mclk = ~mclk;
  wdc_top wdc_top_inst (.mclk(mclk), .rst_n(rst_n), .tck(tck), .tdi(tdi),
    .scanCapture(scanCapture), .scanShift(scanShift), .tdo(tdo),
    .scanUpdate(scanUpdate), .scanChain2Sel(scanChain2Sel),
    .tstRst_n(tstRst_n), .fetchAddr(fetchAddr), .fetchData(fetchData),
    .fetchValid(fetchValid), .instrSetState(instrSetState),
    .fetchNotTranslate(fetchNotTranslate),
    .externalCondition(externalCondition),
    .externalDebugRequest(externalDebugRequest), .irqIn(irqIn),
    .coreDebugAck(coreDebugAck), .instrExecuted(instrExecuted),
    .fiqIn(fiqIn), .instrBreakpointSignal(instrBreakpointSignal),
    .prefetchAbort(prefetchAbort), .debugRequestCore(debugRequestCore),
    .debugAcknowledge(debugAcknowledge), .irqCore(irqCore),
    .fiqCore(fiqCore));
  wdc_dbg_model wdc_dbg_model_inst (.tck(tck), .tdi(tdi), .tdo(tdo),
    .scanCapture(scanCapture), .scanShift(scanShift),
    .scanUpdate(scanUpdate), .scanChain2Sel(scanChain2Sel));
  // ==========================================================
  // Helpers
  task automatic end_sim();
    if (num_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  function automatic logic gate(input logic r, input logic [5:0] c);
    return r & ~(c[0] | coreDebugAck) & ~c[2];
  endfunction
  task automatic wr(input logic [4:0] a, input logic [31:0] dt);
    logic [37:0] s;
    @(posedge mclk);
    wdc_dbg_model_inst.frame({1'b1, a, dt}, s);
  endtask
  // Second frame captures the address sent by the first
  task automatic rdChk(input logic [4:0] a, input logic [31:0] exp);
    logic [37:0] s;
    @(posedge mclk);
    wdc_dbg_model_inst.frame({1'b0, a, 32'h0}, s);
    @(posedge mclk);
    wdc_dbg_model_inst.frame({1'b0, a, 32'h0}, s);
    chk(s[31:0], exp);
  endtask
  task automatic wp(input logic [1:0] b, input logic [31:0] av,
      input logic [8:0] cv, input logic [7:0] cm);
    wr({b, `WDC_SUB_ADDR_VAL}, av);
    wr({b, `WDC_SUB_ADDR_MSK}, 32'h0);
    wr({b, `WDC_SUB_DATA_MSK}, 32'hffffffff);
    wr({b, `WDC_SUB_CTRL_MSK}, {24'h0, cm});
    wr({b, `WDC_SUB_CTRL_VAL}, {23'h0, cv});
  endtask
  // f is {condition 0, privilege, compact}; condition needs sync time
  task automatic fetch(input logic [31:0] a, input logic [2:0] f,
      input logic bp, input logic pa);
    @(posedge mclk);
    fetchAddr <= a;
    {externalCondition[0], fetchNotTranslate, instrSetState} <= f;
    repeat (4) @(posedge mclk);
    fetchValid <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk(instrBreakpointSignal, bp);
    chk(prefetchAbort, pa);
    @(posedge mclk);
    fetchValid <= 1'b0;
  endtask
  // ==========================================================
  // Sequence
  initial begin
    #400000;
    num_errors++;
    end_sim();
  end
  initial begin
    fetchData = 32'($random(seed));
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    tstRst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rdChk(`WDC_ADDR_DBG_CTRL, 32'h10);
    for (i = 0; i < 8; i++) begin
      // Step bit kept clear: it only means something in debug state
      v = 6'($random(seed)) & 6'h37;
      @(posedge mclk);
      {coreDebugAck, externalDebugRequest, irqIn, fiqIn} <= 4'($random(seed));
      wr(`WDC_ADDR_DBG_CTRL, {26'h0, v});
      rdChk(`WDC_ADDR_DBG_CTRL, {26'h0, v});
      chk(debugAcknowledge, v[0] | coreDebugAck);
      chk(debugRequestCore, v[1] | externalDebugRequest);
      chk(irqCore, gate(irqIn, v));
      chk(fiqCore, gate(fiqIn, v));
    end
    wr(5'h1f, 32'($random(seed)));
    rdChk(5'h1f, 32'h0);
    @(posedge mclk);
    {coreDebugAck, externalDebugRequest, irqIn, fiqIn} <= 4'h0;
    a0 = 32'($random(seed));
    a1 = ~a0;
    wr(`WDC_ADDR_DBG_CTRL, 32'h0);
    wp(`WDC_WP0_BASE, a0, 9'h132, 8'hcd);
    rdChk({`WDC_WP0_BASE, `WDC_SUB_CTRL_VAL}, 32'h132);
    fetch(a0, 3'h7, 1'b1, 1'b0);
    for (i = 0; i < 3; i++) begin
      fetch(a0, 3'h7 ^ (3'h1 << i), 1'b0, 1'b0);
    end
    fetch(a1, 3'h7, 1'b0, 1'b0);
    wr(`WDC_ADDR_DBG_CTRL, 32'h10);
    fetch(a0, 3'h7, 1'b0, 1'b1);
    wr(`WDC_ADDR_DBG_CTRL, 32'h20);
    fetch(a0, 3'h7, 1'b0, 1'b0);
    wr(`WDC_ADDR_DBG_CTRL, 32'h0);
    wr({`WDC_WP0_BASE, `WDC_SUB_CTRL_VAL}, 32'h32);
    fetch(a0, 3'h7, 1'b0, 1'b0);
    wp(`WDC_WP1_BASE, a1, 9'h000, 8'hff);
    wp(`WDC_WP0_BASE, a0, 9'h172, 8'h8d);
    fetch(a0, 3'h7, 1'b0, 1'b0);
    fetch(a1, 3'h7, 1'b0, 1'b0);
    fetch(a0, 3'h7, 1'b1, 1'b0);
    @(posedge mclk);
    tstRst_n <= 1'b0;
    repeat (6) @(posedge mclk);
    tstRst_n <= 1'b1;
    fetch(a0, 3'h7, 1'b0, 1'b0);
    fetch(a1, 3'h7, 1'b0, 1'b0);
    // Leave a1 first, or watchpoint 1 reloads its latch after the clear
    fetch(a0, 3'h7, 1'b1, 1'b0);
    wr({`WDC_WP1_BASE, `WDC_SUB_CTRL_VAL}, 32'h0);
    fetch(a0, 3'h7, 1'b0, 1'b0);
    wp(`WDC_WP0_BASE, a0, 9'h1b2, 8'h4d);
    fetch(a0, 3'h7, 1'b0, 1'b0);
    wr({`WDC_WP1_BASE, `WDC_SUB_ADDR_MSK}, 32'hffffffff);
    fetch(a0, 3'h7, 1'b1, 1'b0);
    @(posedge mclk);
    coreDebugAck <= 1'b1;
    wr(`WDC_ADDR_DBG_CTRL, 32'h08);
    @(posedge mclk);
    coreDebugAck <= 1'b0;
    repeat (3) @(posedge mclk);
    instrExecuted <= 1'b1;
    @(posedge mclk);
    instrExecuted <= 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    chk(instrBreakpointSignal, 1'b1);
    @(posedge mclk);
    coreDebugAck <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk(instrBreakpointSignal, 1'b0);
    end_sim();
  end
endmodule
